/* File: src/pxb_pkg.sv */
// Package for the peripheral expansion bus controller
package pxb_pkg;

	localparam int PXB_NCS      = 8;
	localparam int PXB_AW       = 24;
	localparam int PXB_DW       = 16;
	localparam int PXB_PHW      = 4;
	localparam int PXB_NPH      = 5;
	localparam int PXB_DSP_CS0  = 4;
	localparam int PXB_SYS_MHZ  = 25;
	// Clock output divider: half periods in system cycles
	localparam logic [7:0] PXB_CLK_HI_RST = 8'h01;
	localparam logic [7:0] PXB_CLK_LO_RST = 8'h01;
	localparam logic [PXB_PHW-1:0] PXB_PH_RST = 4'h1;

	typedef enum logic [5:0]
	{
		PXB_IDLE  = 6'h01,
		PXB_ADDR  = 6'h02,
		PXB_SETUP = 6'h04,
		PXB_STRB  = 6'h08,
		PXB_HOLD  = 6'h10,
		PXB_RECOV = 6'h20
	} pxb_state_t;

	// Per chip select timing and style
	typedef struct packed
	{
		logic [PXB_NPH-1:0][PXB_PHW-1:0] ph_len;
		logic                            mux_mode;
		logic                            moto_style;
		logic                            dsp_en;
		logic                            dsp_halfword;
	} pxb_cfg_t;

	typedef struct packed
	{
		logic              valid;
		logic              write;
		logic [2:0]        cs;
		logic [PXB_AW-1:0] addr;
		logic [PXB_DW-1:0] wdata;
	} pxb_req_t;

	typedef struct packed
	{
		logic [PXB_AW-1:0] addr;
		logic [PXB_DW-1:0] dout;
		logic [PXB_DW-1:0] doe_n;
		logic [PXB_NCS-1:0] cs_n;
		logic              rd_n;
		logic              wr_n;
		logic              ale;
	} pxb_pins_t;

endpackage

/* File: src/pxb_ctrl.sv */
// Peripheral expansion bus controller: five-phase accesses, strap capture, clock out
//Contract
//- The bus has 16 data bits, eight chip selects and 24 address lines per select.
//- Each access runs through five phases: address, setup, strobe, hold, recovery.
//- Each phase length comes from per-chip-select configuration.
//- Strobes follow either of two processor signalling styles chosen by configuration.
//- Each chip select runs multiplexed or separate address and data.
//- Chip selects 4 to 7 may run DSP host-port cycles, byte or halfword.
//- The 24 address pin levels are captured as straps when reset releases.
//- General-purpose pin 15 leaves reset as an output and can clock the interface.
//- Pin 15 as clock output runs up to 33.33 MHz with selectable duty cycle.
`timescale 1ns/100ps
module pxb_ctrl
	import pxb_pkg::*;
(
	input  wire logic                    clk_sys,
	input  wire logic                    nrst,
	input  wire pxb_cfg_t [PXB_NCS-1:0]  cs_cfg,
	input  wire pxb_req_t                req,
	output logic                         req_ready,
	output logic                         rsp_valid,
	output logic [PXB_DW-1:0]            rsp_rdata,
	output pxb_pins_t                    pins,
	input  wire logic [PXB_AW-1:0]       addr_in,
	input  wire logic [PXB_DW-1:0]       data_in,
	output logic [PXB_AW-1:0]            strap_q,
	input  wire logic                    gp15_clk_en,
	input  wire logic [7:0]              gp15_hi_len,
	input  wire logic [7:0]              gp15_lo_len,
	output logic                         gp15_out,
	output logic                         gp15_oe_n
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [PXB_AW-1:0] addr_s1_q;
	logic [PXB_AW-1:0] addr_s2_q;
	logic [PXB_DW-1:0] data_s1_q;
	logic [PXB_DW-1:0] data_s2_q;

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			addr_s1_q <= '0;
			addr_s2_q <= '0;
			data_s1_q <= '0;
			data_s2_q <= '0;
		end
		else
		begin
			addr_s1_q <= addr_in;
			addr_s2_q <= addr_s1_q;
			data_s1_q <= data_in;
			data_s2_q <= data_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------
	// Pins are released until capture so pull resistors set the levels
	logic [1:0] strap_cnt_q;
	logic       strap_done_q;

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			strap_cnt_q  <= 2'h0;
			strap_done_q <= 1'b0;
			strap_q      <= '0;
		end
		else if (!strap_done_q)
		begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == 2'h2)
			begin
				strap_q      <= addr_s2_q;
				strap_done_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Access sequencer
	// ------------------------------------------------------------
	pxb_state_t        state_q;
	pxb_req_t          cur_q;
	pxb_cfg_t          ccfg;
	logic [PXB_PHW-1:0] ph_cnt_q;
	logic              dsp_cyc;
	logic              byte_hi_q;

	function automatic logic [PXB_PHW-1:0] phase_len(pxb_cfg_t c, int idx);
		phase_len = c.ph_len[idx];
	endfunction

	assign ccfg    = cs_cfg[cur_q.cs];
	// Host-port cycles only exist on the upper four selects
	assign dsp_cyc = ccfg.dsp_en && (cur_q.cs >= 3'(PXB_DSP_CS0));

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q   <= PXB_IDLE;
			ph_cnt_q  <= '0;
			cur_q     <= '0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			byte_hi_q <= 1'b0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			req_ready <= 1'b0;
			unique case (state_q)
				PXB_IDLE:
				begin
					req_ready <= strap_done_q;
					if (req.valid && req_ready)
					begin
						cur_q     <= req;
						req_ready <= 1'b0;
						byte_hi_q <= 1'b0;
						ph_cnt_q  <= phase_len(cs_cfg[req.cs], 0);
						state_q   <= PXB_ADDR;
					end
				end
				PXB_ADDR, PXB_SETUP, PXB_STRB, PXB_HOLD, PXB_RECOV:
				begin
					if (ph_cnt_q != '0)
						ph_cnt_q <= ph_cnt_q - PXB_PHW'(1);
					else
					begin
						unique case (state_q)
							PXB_ADDR:
							begin
								state_q  <= PXB_SETUP;
								ph_cnt_q <= phase_len(ccfg, 1);
							end
							PXB_SETUP:
							begin
								state_q  <= PXB_STRB;
								ph_cnt_q <= phase_len(ccfg, 2);
							end
							PXB_STRB:
							begin
								// Read data sampled at strobe end; byte mode fills low then high
								if (dsp_cyc && !ccfg.dsp_halfword && byte_hi_q)
									rsp_rdata[15:8] <= data_s2_q[7:0];
								else
									rsp_rdata <= data_s2_q;
								state_q  <= PXB_HOLD;
								ph_cnt_q <= phase_len(ccfg, 3);
							end
							PXB_HOLD:
							begin
								state_q  <= PXB_RECOV;
								ph_cnt_q <= phase_len(ccfg, 4);
							end
							default:
							begin
								if (dsp_cyc && !ccfg.dsp_halfword && !byte_hi_q)
								begin
									// Second byte of a halfword on the 8-bit host port
									byte_hi_q <= 1'b1;
									state_q   <= PXB_SETUP;
									ph_cnt_q  <= phase_len(ccfg, 1);
								end
								else
								begin
									rsp_valid <= 1'b1;
									state_q   <= PXB_IDLE;
								end
							end
						endcase
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	logic strobe;
	logic drive_d;
	logic [PXB_DW-1:0] wd;

	assign strobe  = (state_q == PXB_STRB);
	assign drive_d = cur_q.write && (state_q inside {PXB_SETUP, PXB_STRB, PXB_HOLD});
	assign wd      = (dsp_cyc && !ccfg.dsp_halfword && byte_hi_q)
		? {8'h00, cur_q.wdata[15:8]} : cur_q.wdata;

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			pins <= '{addr: '0, dout: '0, doe_n: '1, cs_n: '1, rd_n: 1'b1, wr_n: 1'b1,
				ale: 1'b0};
		end
		else
		begin
			pins.addr <= cur_q.addr;
			pins.cs_n <= '1;
			if (state_q != PXB_IDLE)
				pins.cs_n[cur_q.cs] <= 1'b0;
			pins.ale   <= (state_q == PXB_ADDR);
			pins.doe_n <= '1;
			pins.dout  <= wd;
			if (ccfg.mux_mode && state_q == PXB_ADDR)
			begin
				// Multiplexed: low address word shares the data lines
				pins.dout  <= cur_q.addr[PXB_DW-1:0];
				pins.doe_n <= '0;
			end
			else if (drive_d)
				pins.doe_n <= '0;
			if (ccfg.moto_style)
			begin
				// rd_n carries direction, wr_n the data strobe
				pins.rd_n <= !cur_q.write || state_q == PXB_IDLE;
				pins.wr_n <= !strobe;
			end
			else
			begin
				pins.rd_n <= !(strobe && !cur_q.write);
				pins.wr_n <= !(strobe && cur_q.write);
			end
		end
	end

	// ------------------------------------------------------------
	// Pin 15 clock output
	// ------------------------------------------------------------
	// Fastest setting toggles every cycle; the slow system clock keeps it under 33.33 MHz
	logic [7:0] div_q;

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			gp15_oe_n <= 1'b0;
			gp15_out  <= 1'b0;
			div_q     <= PXB_CLK_LO_RST;
		end
		else
		begin
			gp15_oe_n <= 1'b0;
			if (!gp15_clk_en)
			begin
				gp15_out <= 1'b0;
				div_q    <= '0;
			end
			else if (div_q <= 8'h01)
			begin
				gp15_out <= !gp15_out;
				div_q    <= gp15_out ? gp15_lo_len : gp15_hi_len;
			end
			else
				div_q <= div_q - 8'h01;
		end
	end

endmodule

/* File: verif/pxb_chk.sv */
// Port checker for the expansion bus controller
`timescale 1ns/100ps
module pxb_chk
	import pxb_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              nrst,
	input wire pxb_req_t          req,
	input wire logic              req_ready,
	input wire logic              rsp_valid,
	input wire pxb_pins_t         pins,
	input wire logic [PXB_AW-1:0] strap_q,
	input wire logic              gp15_oe_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	wire logic sel = pins.cs_n != '1;
	// ---
	// Properties
	// ---
	one_select_a: assert property ($onehot0(~pins.cs_n)) else $error("two selects");
	take_select_a: assert property (req.valid && req_ready |-> ##[1:3] sel)
		else $error("no select");
	busy_ready_a: assert property (sel |-> !req_ready) else $error("ready in access");
	rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid && req_ready)
		else $error("bad end");
	wr_select_a: assert property (!pins.wr_n |-> sel) else $error("stray strobe");
	ale_select_a: assert property (pins.ale |-> sel) else $error("stray ale");
	drive_select_a: assert property (pins.doe_n != '1 |-> sel) else $error("stray drive");
	strap_keep_a: assert property (req_ready && $past(req_ready) |-> $stable(strap_q))
		else $error("straps moved");
	pin_out_a: assert property (gp15_oe_n == 1'b0) else $error("pin 15 input");
	cover property (req.valid && req_ready && req.write);
	cover property (req.valid && req_ready && !req.write);
	cover property (pins.ale);
endmodule
bind pxb_ctrl pxb_chk i_chk (.clk_sys(clk_sys), .nrst(nrst), .req(req),
	.req_ready(req_ready), .rsp_valid(rsp_valid), .pins(pins),
	.strap_q(strap_q), .gp15_oe_n(gp15_oe_n));

/* File: verif/pxb_dev.sv */
// Far-side memory model on the bus pins
`timescale 1ns/100ps
module pxb_dev
	import pxb_pkg::*;
(
	input wire logic              clk_sys,
	input wire pxb_pins_t         pins,
	input wire logic              mux,
	input wire logic              moto,
	input wire logic              hpb,
	output logic [PXB_DW-1:0]     data_in,
	output logic [PXB_NCS-1:0]    cs_seen
);
	logic [PXB_DW-1:0] mem [16];
	logic [3:0]        a_q;
	logic [PXB_DW-1:0] last_q = '0;
	logic              stb_q = 1'b0;
	logic              hi_q = 1'b0;
	wire logic sel = pins.cs_n != '1;
	// Second style: rd_n gives direction, wr_n strobes
	wire logic stb = moto ? !pins.wr_n : !(pins.wr_n && pins.rd_n);
	wire logic wr = moto ? !pins.rd_n : !pins.wr_n;
	wire logic [3:0] a = mux ? a_q : pins.addr[3:0];
	// Released lines flip so stale data never passes
	// Byte host port: low byte first, then high byte, both on bits 7:0
	wire logic [PXB_DW-1:0] rd_w = !hpb ? mem[a]
		: hi_q ? {8'h00, mem[a][15:8]} : {8'h00, mem[a][7:0]};
	assign data_in = sel && stb && !wr ? rd_w : ~last_q;
	always @(posedge clk_sys)
	begin
		last_q <= data_in;
		stb_q  <= sel && stb;
		if (!sel)
			hi_q <= 1'b0;
		else if (hpb && stb_q && !stb)
			hi_q <= ~hi_q;
		if (pins.ale)
			a_q <= pins.dout[3:0];
		if (sel)
			cs_seen <= pins.cs_n;
		if (sel && stb && wr && pins.doe_n == '0)
		begin
			if (!hpb)
				mem[a] <= pins.dout;
			else if (hi_q)
				mem[a][15:8] <= pins.dout[7:0];
			else
				mem[a][7:0] <= pins.dout[7:0];
		end
	end
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the expansion bus controller
`timescale 1ns/100ps
module tb;
	import pxb_pkg::*;
	logic                   clk_sys = 0;
	logic                   nrst = 0;
	pxb_cfg_t [PXB_NCS-1:0] cfg = '0;
	pxb_req_t               req = '0;
	logic                   ready, rsp, g_out, g_oe_n, g_en = 0;
	logic [15:0]            rdata, data_in;
	logic [23:0]            addr_in = '0, strap;
	logic [7:0]             cs_seen, hi = 8'h01, lo = 8'h01;
	pxb_pins_t              pins;
	int                     n_mismatch = 0, n_tests = 0, mem [16];
	int unsigned            seed = 41336;
	always #20 clk_sys = ~clk_sys;
	pxb_ctrl i_dut (.clk_sys(clk_sys), .nrst(nrst), .cs_cfg(cfg), .req(req),
		.req_ready(ready), .rsp_valid(rsp), .rsp_rdata(rdata), .pins(pins),
		.addr_in(addr_in), .data_in(data_in), .strap_q(strap), .gp15_clk_en(g_en),
		.gp15_hi_len(hi), .gp15_lo_len(lo), .gp15_out(g_out), .gp15_oe_n(g_oe_n));
	pxb_dev i_dev (.clk_sys(clk_sys), .pins(pins), .mux(cfg[req.cs].mux_mode),
		.moto(cfg[req.cs].moto_style),
		.hpb(cfg[req.cs].dsp_en && req.cs[2] && !cfg[req.cs].dsp_halfword),
		.data_in(data_in), .cs_seen(cs_seen));
	// ---
	// Helpers
	// ---
	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic acc(input logic w, input logic [2:0] cs, input logic [23:0] ad,
		input logic [15:0] d, output logic [15:0] q, output int n);
		req <= '{1'b1, w, cs, ad, d};
		for (n = 0; n < 200 && ready !== 1'b1; n++)
			@(negedge clk_sys);
		if (n >= 200)
			chk(1'b0, "no ready");
		@(negedge clk_sys);
		req.valid <= 1'b0;
		for (n = 0; n < 200 && rsp !== 1'b1; n++)
			@(negedge clk_sys);
		q = rdata;
		if (n >= 200)
		begin
			chk(1'b0, "timeout");
			end_of_test();
		end
	endtask
	// ---
	// Sequence
	// ---
	initial
	begin
		logic [15:0] q, s;
		logic [23:0] ad;
		logic [2:0]  cs;
		logic        hb;
		int          n, sum;
		// Second pass is a reset in mid-run with new straps
		for (int r = 0; r < 2; r++)
		begin
			ad = 24'(rnd());
			addr_in = ad;
			nrst = 0;
			repeat (16) @(negedge clk_sys);
			chk(pins.cs_n === 8'hff && ready === 1'b0, "reset pins");
			chk(pins.doe_n === 16'hffff && rsp === 1'b0, "reset drive");
			nrst = 1;
			repeat (8) @(negedge clk_sys);
			// Moving the pins later must not disturb the captured straps
			addr_in = ~ad;
			repeat (4) @(negedge clk_sys);
			chk(strap === ad, "straps");
			chk(g_oe_n === 1'b0, "pin 15 dir");
		end
		$display("reset test done");
		for (int i = 0; i < 24; i++)
		begin
			cs = 3'(rnd());
			// First accesses force host-port cycles on the upper selects
			if (i < 4)
				cs[2] = 1'b1;
			ad = 24'(rnd());
			s = 16'(rnd());
			cfg[cs] = 24'(rnd());
			if (i < 4)
			begin
				cfg[cs].dsp_en = 1'b1;
				cfg[cs].dsp_halfword = i[0];
			end
			hb = cfg[cs].dsp_en && cs[2] && !cfg[cs].dsp_halfword;
			// Strobe long enough for the input synchronisers
			cfg[cs].ph_len[2] |= 4'h3;
			sum = 0;
			for (int p = 0; p < 5; p++)
				sum += (cfg[cs].ph_len[p] + 1) * ((hb && p > 0) ? 2 : 1);
			acc(1'b1, cs, ad, s, q, n);
			chk(n >= sum && n <= sum + 4, "access length");
			chk(cs_seen === ~(8'h01 << cs), "select line");
			mem[ad[3:0]] = s;
			acc(1'b0, cs, ad, 16'h0, q, n);
			chk(q === 16'(mem[ad[3:0]]), "read data");
		end
		$display("access test done");
		hi = 8'h02;
		g_en = 1;
		repeat (6) @(negedge clk_sys);
		n = 0;
		for (int i = 0; i < 30; i++)
		begin
			@(negedge clk_sys);
			n += (g_out === 1'b1);
		end
		chk(n == 20, "clock duty");
		$display("clock test done");
		end_of_test();
	end
endmodule
